// ---- rtl/boot_pkg.sv ----
// Purpose: Constants for program memory selection and configuration loading
// Assumes: One clock, mclk at 20 MHz; byte-wide memory read ports
// Notes:   Constant and type list follows
package boot_pkg;
  localparam int          PA_W        = 16;
  localparam int          RA_W        = 8;
  localparam int          WORD_W      = 24;
  localparam int          CFG_WORDS   = 16;
  localparam int          CFG_BYTES   = 48;
  localparam int          UEE_DEPTH   = 128;
  localparam logic [12:0] USER_LAST   = 13'h1fff;
  localparam logic [7:0]  BLANK_LO    = 8'h00;
  localparam logic [7:0]  BLANK_HI    = 8'hff;
  localparam logic [15:0] ROM_BASE    = 16'hf000;
  localparam logic [15:0] USER_TOP    = 16'h1fff;
  localparam logic [7:0]  CFG_RAM_LO  = 8'h30;
  localparam logic [7:0]  MIRROR_LO   = 8'hf0;
  localparam logic [7:0]  MIRROR_SRC  = 8'h10;
  localparam logic [7:0]  INTREG_LO   = 8'h51;
  localparam logic [7:0]  UART_LO     = 8'h56;
  localparam logic [7:0]  RSVD_LO     = 8'h5c;
  localparam logic [7:0]  URAM_LO     = 8'h60;
  localparam logic [7:0]  SYSRAM_LO   = 8'hd0;
  localparam logic [1:0]  BYTE_LAST   = 2'h2;

  typedef enum logic [2:0] {
    RG_USER   = 3'b001,
    RG_SYSTEM = 3'b010,
    RG_OTHER  = 3'b100
  } region_t;

  typedef enum logic [5:0] {
    ST_PROBE  = 6'b000001,
    ST_PWAIT  = 6'b000010,
    ST_FETCH  = 6'b000100,
    ST_FWAIT  = 6'b001000,
    ST_STORE  = 6'b010000,
    ST_RUN    = 6'b100000
  } boot_state_t;
endpackage : boot_pkg

// ---- rtl/pmem_if.sv ----
// Purpose: Byte read channel from the loader to the program memory mux
// Assumes: Single clock domain
// Notes:   Request held until ready
`timescale 1ns/100ps
interface pmem_if;
  logic        req;
  logic [12:0] addr;
  logic        ext_sel;
  logic        ready;
  logic [7:0]  data;
  modport master (output req, output addr, output ext_sel, input ready, input data);
  modport slave  (input req, input addr, input ext_sel, output ready, output data);
endinterface : pmem_if

// ---- rtl/pmem_mux.sv ----
// Purpose: Steers program byte reads to OTP or external EEPROM
// Assumes: Each memory answers with a ready pulse
// Notes:   Combinational steering only
`timescale 1ns/100ps
module pmem_mux
  import boot_pkg::*;
(
  // Channel
  pmem_if.slave            ch,
  // OTP
  output logic             otp_req,
  output logic [12:0]      otp_addr,
  input  wire logic        otp_ready,
  input  wire logic [7:0]  otp_data,
  // External
  output logic             ext_req,
  output logic [12:0]      ext_addr,
  input  wire logic        ext_ready,
  input  wire logic [7:0]  ext_data
);
  always_comb begin
    otp_req  = ch.req & ~ch.ext_sel;
    ext_req  = ch.req & ch.ext_sel;
    otp_addr = ch.addr;
    ext_addr = ch.addr;
    // Slower external answers stretch the wait, nothing else differs
    ch.ready = ch.ext_sel ? ext_ready : otp_ready;
    ch.data  = ch.ext_sel ? ext_data : otp_data;
  end
endmodule : pmem_mux

// ---- rtl/ram_addr_map.sv ----
// Purpose: Decodes the RAM address pointer into RAM or user EEPROM access
// Assumes: Pointer is 8 bits wide
// Notes:   Mirror window folds onto 16..31
`timescale 1ns/100ps
module ram_addr_map
  import boot_pkg::*;
(
  input  wire logic [7:0] ptr,
  input  wire logic       epr_op,
  output logic [7:0]      ram_addr,
  output logic [6:0]      uee_addr,
  output logic            uee_sel,
  output region_t         region
);
  always_comb begin
    uee_sel  = epr_op;
    uee_addr = ptr[6:0];
    ram_addr = ptr;
    if (ptr >= MIRROR_LO) begin
      ram_addr = MIRROR_SRC | {4'h0, ptr[3:0]};
    end
    if (ptr >= SYSRAM_LO && ptr < MIRROR_LO) begin
      region = RG_SYSTEM;
    end else if ((ptr >= URAM_LO && ptr < SYSRAM_LO) || ptr < INTREG_LO) begin
      region = RG_USER;
    end else begin
      region = RG_OTHER;
    end
  end
endmodule : ram_addr_map

// ---- rtl/boot_loader.sv ----
// Purpose: Power-up program memory selection, config copy and memory maps
// Assumes: Memories answer reads with a one-cycle ready pulse
// Notes:   CPU is held until the config copy is finished
`timescale 1ns/100ps
module boot_loader
  import boot_pkg::*;
(
  // System
  input  wire logic        mclk,
  input  wire logic        reset,
  // OTP byte port
  output logic             otp_req,
  output logic [12:0]      otp_addr,
  input  wire logic        otp_ready,
  input  wire logic [7:0]  otp_data,
  // External EEPROM byte port
  output logic             ext_req,
  output logic [12:0]      ext_addr,
  input  wire logic        ext_ready,
  input  wire logic [7:0]  ext_data,
  // CPU fetch
  input  wire logic        cpu_fetch,
  input  wire logic [15:0] cpu_pc,
  output logic             fetch_ready_ff,
  output logic [7:0]       fetch_data_ff,
  output logic             fetch_rom_ff,
  input  wire logic [7:0]  rom_data,
  output logic             cpu_run_ff,
  output logic             ext_sel_ff,
  // Config write to RAM
  output logic             cfg_we_ff,
  output logic [7:0]       cfg_addr_ff,
  output logic [23:0]      cfg_word_ff,
  // RAM pointer decode
  input  wire logic [7:0]  ram_ptr,
  input  wire logic        epr_op,
  output logic [7:0]       ram_addr_ff,
  output logic [6:0]      uee_addr_ff,
  output logic             uee_sel_ff
);
  pmem_if pm ();

  boot_state_t  state_ff, nxt_state;
  logic [3:0]   widx_ff, nxt_widx;
  logic [1:0]   bidx_ff, nxt_bidx;
  logic [23:0]  acc_ff, nxt_acc;
  logic         ext_ff, nxt_ext;
  logic         run_ff, nxt_run;
  logic         we_ff, nxt_we;
  logic [7:0]   wa_ff, nxt_wa;
  logic         fr_ff, nxt_fr;
  logic [7:0]   fd_ff, nxt_fd;
  logic         from_ff, nxt_from;
  logic         fpend_ff, nxt_fpend;
  logic [7:0]   map_ram;
  logic [6:0]   map_uee;
  logic         map_sel;
  region_t      map_region;
  logic [5:0]   byte_addr;
  logic         is_rom;

  pmem_mux u_mux (
    .ch        (pm.slave),
    .otp_req   (otp_req),
    .otp_addr  (otp_addr),
    .otp_ready (otp_ready),
    .otp_data  (otp_data),
    .ext_req   (ext_req),
    .ext_addr  (ext_addr),
    .ext_ready (ext_ready),
    .ext_data  (ext_data)
  );

  ram_addr_map u_map (
    .ptr      (ram_ptr),
    .epr_op   (epr_op),
    .ram_addr (map_ram),
    .uee_addr (map_uee),
    .uee_sel  (map_sel),
    .region   (map_region)
  );

  // ----------------------------------------
  // Loader sequence
  // ----------------------------------------
  assign byte_addr = 6'(widx_ff * 3) + 6'(bidx_ff);
  assign is_rom    = cpu_pc >= ROM_BASE;

  always_comb begin
    nxt_state = state_ff;
    nxt_widx  = widx_ff;
    nxt_bidx  = bidx_ff;
    nxt_acc   = acc_ff;
    nxt_ext   = ext_ff;
    nxt_run   = run_ff;
    nxt_we    = 1'b0;
    nxt_wa    = wa_ff;
    nxt_fr    = 1'b0;
    nxt_fd    = fd_ff;
    nxt_from  = from_ff;
    nxt_fpend = fpend_ff;
    pm.req     = 1'b0;
    pm.addr    = 13'h0000;
    pm.ext_sel = ext_ff;
    case (state_ff)
      ST_PROBE: begin
        nxt_state = ST_PWAIT;
      end
      ST_PWAIT: begin
        pm.req     = 1'b1;
        pm.ext_sel = 1'b1;
        if (pm.ready) begin
          // Missing device reads blank, so no separate presence check
          nxt_ext   = pm.data != BLANK_LO && pm.data != BLANK_HI;
          nxt_state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        nxt_state = ST_FWAIT;
      end
      ST_FWAIT: begin
        pm.req  = 1'b1;
        pm.addr = {7'h00, byte_addr};
        if (pm.ready) begin
          // First byte lands in bits 23:16
          nxt_acc = {acc_ff[15:0], pm.data};
          if (bidx_ff == BYTE_LAST) begin
            nxt_bidx  = 2'h0;
            nxt_state = ST_STORE;
          end else begin
            nxt_bidx  = bidx_ff + 2'h1;
            nxt_state = ST_FETCH;
          end
        end
      end
      ST_STORE: begin
        nxt_we = 1'b1;
        nxt_wa = CFG_RAM_LO + {4'h0, widx_ff};
        if (widx_ff == 4'(CFG_WORDS - 1)) begin
          nxt_state = ST_RUN;
          nxt_run   = 1'b1;
        end else begin
          nxt_widx  = widx_ff + 4'h1;
          nxt_state = ST_FETCH;
        end
      end
      ST_RUN: begin
        if (cpu_fetch || fpend_ff) begin
          if (is_rom) begin
            nxt_fr    = 1'b1;
            nxt_fd    = rom_data;
            nxt_from  = 1'b1;
            nxt_fpend = 1'b0;
          end else begin
            // Returning from ROM lands in whichever user memory was chosen
            pm.req    = 1'b1;
            pm.addr   = cpu_pc[12:0];
            nxt_fpend = ~pm.ready;
            nxt_from  = 1'b0;
            if (pm.ready) begin
              nxt_fr = 1'b1;
              nxt_fd = pm.data;
            end
          end
        end
      end
      default: begin
        nxt_state = ST_PROBE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_ff <= ST_PROBE;
      widx_ff  <= 4'h0;
      bidx_ff  <= 2'h0;
      acc_ff   <= 24'h000000;
      ext_ff   <= 1'b0;
      run_ff   <= 1'b0;
      we_ff    <= 1'b0;
      wa_ff    <= 8'h00;
      fr_ff    <= 1'b0;
      fd_ff    <= 8'h00;
      from_ff  <= 1'b0;
      fpend_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      widx_ff  <= nxt_widx;
      bidx_ff  <= nxt_bidx;
      acc_ff   <= nxt_acc;
      ext_ff   <= nxt_ext;
      run_ff   <= nxt_run;
      we_ff    <= nxt_we;
      wa_ff    <= nxt_wa;
      fr_ff    <= nxt_fr;
      fd_ff    <= nxt_fd;
      from_ff  <= nxt_from;
      fpend_ff <= nxt_fpend;
    end
  end

  // ----------------------------------------
  // RAM pointer decode registers
  // ----------------------------------------
  logic [7:0] rad_ff, nxt_rad;
  logic [6:0] uad_ff, nxt_uad;
  logic       usel_ff, nxt_usel;

  // Window above 239 reads back 16..31, so writes there alias too
  always_comb begin
    nxt_rad  = map_ram;
    nxt_uad  = map_uee;
    nxt_usel = map_sel;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rad_ff  <= 8'h00;
      uad_ff  <= 7'h00;
      usel_ff <= 1'b0;
    end else begin
      rad_ff  <= nxt_rad;
      uad_ff  <= nxt_uad;
      usel_ff <= nxt_usel;
    end
  end

  assign fetch_ready_ff = fr_ff;
  assign fetch_data_ff  = fd_ff;
  assign fetch_rom_ff   = from_ff;
  assign cpu_run_ff     = run_ff;
  assign ext_sel_ff     = ext_ff;
  assign cfg_we_ff      = we_ff;
  assign cfg_addr_ff    = wa_ff;
  assign cfg_word_ff    = acc_ff;
  assign ram_addr_ff    = rad_ff;
  assign uee_addr_ff    = uad_ff;
  assign uee_sel_ff     = usel_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_no_fetch_boot: assert property (@(posedge mclk) disable iff (reset)
    !run_ff |-> !fr_ff) else $error("fetch answered before load done");
  chk_cfg_addr_range: assert property (@(posedge mclk) disable iff (reset)
    we_ff |-> (wa_ff >= CFG_RAM_LO && wa_ff <= CFG_RAM_LO + 8'h0f))
    else $error("config write outside 48..63");
  chk_last_cfg_run: assert property (@(posedge mclk) disable iff (reset)
    (we_ff && wa_ff == CFG_RAM_LO + 8'h0f) |-> run_ff) else $error("run not set at last word");
  chk_sel_stable: assert property (@(posedge mclk) disable iff (reset)
    run_ff |=> $stable(ext_ff)) else $error("memory select changed while running");
  chk_blank_otp: assert property (@(posedge mclk) disable iff (reset)
    (state_ff == ST_PWAIT && ext_ready && (ext_data == BLANK_LO || ext_data == BLANK_HI))
    |=> !ext_ff) else $error("blank byte did not pick OTP");
  chk_rom_fetch: assert property (@(posedge mclk) disable iff (reset)
    (run_ff && cpu_fetch && cpu_pc >= ROM_BASE) |=> (fr_ff && from_ff))
    else $error("ROM fetch not answered from ROM");
  chk_user_route: assert property (@(posedge mclk) disable iff (reset)
    (run_ff && pm.req) |-> (ext_req == ext_ff && otp_req == !ext_ff))
    else $error("user fetch sent to wrong memory");
  chk_mirror_map: assert property (@(posedge mclk) disable iff (reset)
    (ram_ptr >= MIRROR_LO) |=> (ram_addr_ff == (MIRROR_SRC | {4'h0, $past(ram_ptr[3:0])})))
    else $error("mirror window mapped wrong");
  chk_epr_select: assert property (@(posedge mclk) disable iff (reset)
    epr_op |=> (uee_sel_ff && uee_addr_ff == $past(ram_ptr[6:0])))
    else $error("EEPROM op did not select user EEPROM");
  chk_ptr_ram_only: assert property (@(posedge mclk) disable iff (reset)
    !epr_op |=> !uee_sel_ff) else $error("plain op selected user EEPROM");
  chk_ram_pass: assert property (@(posedge mclk) disable iff (reset)
    (ram_ptr < MIRROR_LO) |=> (ram_addr_ff == $past(ram_ptr)))
    else $error("RAM address altered below mirror window");
  chk_run_hold: assert property (@(posedge mclk) disable iff (reset)
    run_ff |=> run_ff) else $error("run dropped without reset");
  chk_probe_addr: assert property (@(posedge mclk) disable iff (reset)
    (state_ff == ST_PWAIT) |-> (ext_req && ext_addr == 13'h0000))
    else $error("probe not aimed at external byte 0");
  chk_cfg_source: assert property (@(posedge mclk) disable iff (reset)
    (state_ff == ST_FWAIT) |-> (pm.addr < 13'(CFG_BYTES) && pm.ext_sel == ext_ff))
    else $error("config byte read outside 0..47 or from wrong memory");
  chk_user_data: assert property (@(posedge mclk) disable iff (reset)
    (run_ff && pm.req && pm.ready) |=> (fr_ff && !from_ff && fd_ff == $past(pm.data)))
    else $error("user fetch byte not passed on");

  // ----------------------------------------
  // Region checks
  // ----------------------------------------
  // Region decode has no port, so only these checks watch it
  chk_sysram_region: assert property (@(posedge mclk) disable iff (reset)
    (ram_ptr >= SYSRAM_LO && ram_ptr < MIRROR_LO) |-> (map_region == RG_SYSTEM))
    else $error("system RAM window decoded wrong");
  chk_other_region: assert property (@(posedge mclk) disable iff (reset)
    (ram_ptr >= INTREG_LO && ram_ptr < URAM_LO) |-> (map_region == RG_OTHER))
    else $error("register window decoded wrong");
  chk_uram_region: assert property (@(posedge mclk) disable iff (reset)
    (ram_ptr >= URAM_LO && ram_ptr < SYSRAM_LO) |-> (map_region == RG_USER))
    else $error("user RAM window decoded wrong");
  chk_mirror_region: assert property (@(posedge mclk) disable iff (reset)
    (ram_ptr >= MIRROR_LO) |-> (map_region == RG_OTHER))
    else $error("mirror window decoded wrong");
endmodule : boot_loader

// ---- dv/prog_mem_model.sv ----
// Purpose: Byte-wide program memory answering held read requests
// Assumes: Requester holds req and addr until ready
// Notes:   Serves as external EEPROM (slow) and as OTP (fast)
`timescale 1ns/100ps
module prog_mem_model #(
  parameter int         LAT  = 0,
  parameter logic [7:0] SEED = 8'h00
) (
  // System
  input  wire logic        mclk,
  input  wire logic        reset,
  // Read port
  input  wire logic        req,
  input  wire logic [12:0] addr,
  output logic             ready,
  output logic [7:0]       data
);
  logic [7:0] mem [0:8191];
  logic [7:0] q_ff;
  logic       ready_ff;
  int         wait_ff;

  initial begin
    for (int i = 0; i < 8192; i++) begin
      mem[i] = i[7:0] ^ i[12:5] ^ SEED;
    end
  end

  // Slow answer makes the loader wait as for a serial part
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ready_ff <= 1'b0;
      q_ff     <= 8'h00;
      wait_ff  <= 0;
    end else if (ready_ff || !req) begin
      ready_ff <= 1'b0;
      wait_ff  <= 0;
    end else if (wait_ff >= LAT) begin
      ready_ff <= 1'b1;
      q_ff     <= mem[addr];
    end else begin
      wait_ff  <= wait_ff + 1;
    end
  end

  assign ready = ready_ff;
  // Released data line shows no stale byte
  assign data  = ready_ff ? q_ff : ~q_ff;
endmodule : prog_mem_model

// ---- dv/program_memory_select_autoconfig_tb_top.sv ----
// Purpose: Self-checking bench for program memory select and config load
// Assumes: Inputs change on the falling edge of mclk
// Notes:   Both program memories are behavioural models
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin errors++; \
  $display("wrong value %s exp %h got %h", nm, exp, got); end end
module program_memory_select_autoconfig_tb_top
  import boot_pkg::*;
();
  logic        mclk, reset, cpu_fetch, epr_op;
  logic        otp_req, otp_ready, ext_req, ext_ready;
  logic [12:0] otp_addr, ext_addr;
  logic [7:0]  otp_data, ext_data, rom_data, ram_ptr, fetch_data_ff;
  logic [7:0]  cfg_addr_ff, ram_addr_ff;
  logic [15:0] cpu_pc;
  logic        fetch_ready_ff, fetch_rom_ff, cpu_run_ff, ext_sel_ff;
  logic        cfg_we_ff, uee_sel_ff;
  logic [23:0] cfg_word_ff;
  logic [6:0]  uee_addr_ff;
  logic [7:0]  cfg_a_q [$];
  logic [23:0] cfg_w_q [$];
  int          errors, n_tests, cyc;

  boot_loader uut (.mclk(mclk), .reset(reset), .otp_req(otp_req), .otp_addr(otp_addr),
    .otp_ready(otp_ready), .otp_data(otp_data), .ext_req(ext_req), .ext_addr(ext_addr),
    .ext_ready(ext_ready), .ext_data(ext_data), .cpu_fetch(cpu_fetch), .cpu_pc(cpu_pc),
    .fetch_ready_ff(fetch_ready_ff), .fetch_data_ff(fetch_data_ff),
    .fetch_rom_ff(fetch_rom_ff), .rom_data(rom_data), .cpu_run_ff(cpu_run_ff),
    .ext_sel_ff(ext_sel_ff), .cfg_we_ff(cfg_we_ff), .cfg_addr_ff(cfg_addr_ff),
    .cfg_word_ff(cfg_word_ff), .ram_ptr(ram_ptr), .epr_op(epr_op),
    .ram_addr_ff(ram_addr_ff), .uee_addr_ff(uee_addr_ff), .uee_sel_ff(uee_sel_ff));
  prog_mem_model #(.LAT(3), .SEED(8'h5a)) ext_m (.mclk(mclk), .reset(reset),
    .req(ext_req), .addr(ext_addr), .ready(ext_ready), .data(ext_data));
  prog_mem_model #(.LAT(0), .SEED(8'ha5)) otp_m (.mclk(mclk), .reset(reset),
    .req(otp_req), .addr(otp_addr), .ready(otp_ready), .data(otp_data));

  assign rom_data = cpu_pc[7:0] ^ 8'hc3;

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Config write monitor and hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cfg_we_ff === 1'b1) begin
      cfg_a_q.push_back(cfg_addr_ff);
      cfg_w_q.push_back(cfg_word_ff);
    end
    if (cyc == 20000) begin
      errors++;
      report_and_stop();
    end
  end

  function automatic logic [7:0] mbyte(input logic sel, input int a);
    return sel ? ext_m.mem[a] : otp_m.mem[a];
  endfunction : mbyte

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic boot(input logic [7:0] b0, input logic exp_ext);
    int k;
    int early;
    logic [23:0] exp_w;
    ext_m.mem[0] = b0;
    early = 0;
    reset = 1'b1;
    repeat (16) @(negedge mclk);
    cfg_a_q.delete();
    cfg_w_q.delete();
    `CHK("run in reset", 1'b0, cpu_run_ff)
    `CHK("request in reset", 1'b0, ext_req | otp_req)
    reset = 1'b0;
    cpu_fetch = 1'b1;
    cpu_pc = 16'h0040;
    @(negedge mclk);
    `CHK("probe request", 1'b1, ext_req)
    `CHK("probe address", 13'h0000, ext_addr)
    k = 0;
    while (cpu_run_ff !== 1'b1 && k < 3000) begin
      @(negedge mclk);
      k++;
      if (fetch_ready_ff === 1'b1) early++;
    end
    cpu_fetch = 1'b0;
    `CHK("early fetch", 0, early)
    `CHK("run with last write", 1'b1, cfg_we_ff)
    `CHK("last write address", CFG_RAM_LO + 8'h0f, cfg_addr_ff)
    // Last word reaches the write monitor one edge later
    @(negedge mclk);
    `CHK("selected memory", exp_ext, ext_sel_ff)
    `CHK("config count", 16, cfg_a_q.size())
    `CHK("count field", mbyte(exp_ext, 0), cfg_w_q[0][23:16])
    for (int w = 0; w < CFG_WORDS; w++) begin
      exp_w = {mbyte(exp_ext, 3*w), mbyte(exp_ext, 3*w+1), mbyte(exp_ext, 3*w+2)};
      `CHK("config address", CFG_RAM_LO + w[7:0], cfg_a_q[w])
      `CHK("config word", exp_w, cfg_w_q[w])
    end
  endtask : boot

  task automatic fetch(input logic [15:0] pc, input logic [7:0] exp_d, input logic exp_rom);
    int k;
    @(negedge mclk);
    cpu_pc = pc;
    cpu_fetch = 1'b1;
    @(negedge mclk);
    cpu_fetch = 1'b0;
    k = 0;
    while (fetch_ready_ff !== 1'b1 && k < 100) begin
      @(negedge mclk);
      k++;
    end
    `CHK("fetch ready", 1'b1, fetch_ready_ff)
    `CHK("fetch data", exp_d, fetch_data_ff)
    `CHK("fetch from rom", exp_rom, fetch_rom_ff)
  endtask : fetch

  task automatic t_ext_boot();
    boot(8'h5a, 1'b1);
    fetch(16'h1fff, ext_m.mem[13'h1fff], 1'b0);
    fetch(16'hf010, 8'h10 ^ 8'hc3, 1'b1);
    fetch(16'h0100, ext_m.mem[13'h0100], 1'b0);
  endtask : t_ext_boot

  task automatic t_select();
    logic [7:0] b0 [4] = '{8'h00, 8'hff, 8'h01, 8'hfe};
    logic       ex [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 4; i++) begin
      boot(b0[i], ex[i]);
      fetch(16'h0123, mbyte(ex[i], 16'h0123), 1'b0);
    end
  endtask : t_select

  task automatic t_ram_map();
    logic [7:0] p [10] = '{8'h03, 8'h04, 8'h7f, 8'hf5, 8'hf0, 8'hff, 8'h51, 8'h5b,
                           8'hd0, 8'hef};
    logic [7:0] a [10] = '{8'h03, 8'h04, 8'h7f, 8'h15, 8'h10, 8'h1f, 8'h51, 8'h5b,
                           8'hd0, 8'hef};
    logic       e [10] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge mclk);
      ram_ptr = p[i];
      epr_op = e[i];
      @(negedge mclk);
      `CHK("eeprom select", e[i], uee_sel_ff)
      if (e[i]) `CHK("eeprom address", a[i][6:0], uee_addr_ff)
      else `CHK("ram address", a[i], ram_addr_ff)
    end
  endtask : t_ram_map

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    reset = 1'b1;
    cpu_fetch = 1'b0;
    cpu_pc = 16'h0000;
    ram_ptr = 8'h00;
    epr_op = 1'b0;
    t_ext_boot();
    t_ram_map();
    t_select();
    report_and_stop();
  end
endmodule : program_memory_select_autoconfig_tb_top
